// file: sfs_pkg.sv
// Purpose: Shared constants and types of the serial flash status/read sequencer.
// Assumes: 50 MHz system clock; serial pins are synchronised inside the block.
// Notes:   Status bit layouts, write masks, opcodes and timing counts live here.
package sfs_pkg;

    // Opcodes
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    localparam logic [7:0] OP_VOL_EN    = 8'h50;
    localparam logic [7:0] OP_RD_STAT1  = 8'h05;
    localparam logic [7:0] OP_RD_STAT2  = 8'h35;
    localparam logic [7:0] OP_RD_STAT3  = 8'h15;
    localparam logic [7:0] OP_WR_STAT1  = 8'h01;
    localparam logic [7:0] OP_WR_STAT2  = 8'h31;
    localparam logic [7:0] OP_WR_STAT3  = 8'h11;
    localparam logic [7:0] OP_READ      = 8'h03;

    // Field positions
    localparam int SR1_BUSY_BIT = 0;
    localparam int SR1_WEL_BIT  = 1;

    // Writable bits per register, one-time, lock and quad-enable bits of register two
    localparam logic [7:0] SR1_WMASK    = 8'hfc;
    localparam logic [7:0] SR2_WMASK    = 8'h7b;
    localparam logic [7:0] SR3_WMASK    = 8'he6;
    localparam logic [7:0] SR2_OTP_MASK = 8'h38;
    localparam logic [7:0] SR2_LOCK1    = 8'h01;
    localparam logic [7:0] SR2_QE       = 8'h02;

    // Stored values after power-up
    localparam logic [7:0] SR1_RST = 8'h00;
    localparam logic [7:0] SR2_RST = 8'h00;
    localparam logic [7:0] SR3_RST = 8'h00;

    // Bit counts
    localparam logic [4:0] LAST_OP_BIT   = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
    localparam logic [4:0] ONE_BYTE      = 5'h08;
    localparam logic [4:0] TWO_BYTES     = 5'h10;
    localparam logic [4:0] BITS_SAT      = 5'h1f;

    // Timing
    localparam int CLK_PERIOD_NS        = 20;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int VOL_REFRESH_TIME_NS  = 50;
    localparam int STATUS_WRITE_CYC =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VOL_REFRESH_CYC  =
        (VOL_REFRESH_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : VOL_REFRESH_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_STAT_OUT, ST_DATA_OUT, ST_STAT_IN, ST_SKIP
    } sfs_state_t;

    typedef enum logic [1:0] {PC_NONE, PC_WR_EN, PC_WR_DIS, PC_VOL_EN} sfs_pend_t;

endpackage

// file: sfs_status_read.sv
// Purpose: Command decoder for write enable/disable, status read/write and plain read.
// Assumes: Host drives chip select, serial clock and data; all pass two flip-flops here.
// Notes:   Array lookup is external: mem_rdata must be valid one clk after mem_addr_q.
`timescale 1ns/1ps

module sfs_status_read
    import sfs_pkg::*;
#(
    parameter int STATUS_WRITE_CYCLES = STATUS_WRITE_CYC,
    parameter int REFRESH_CYCLES      = VOL_REFRESH_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Serial pins to and from host
    input  wire logic        chip_select_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    output logic             serial_out_q,
    output logic             serial_out_en_q,
    // Array read port
    output logic [23:0]      mem_addr_q,
    input  wire logic [7:0]  mem_rdata,
    // Mode and array engine
    input  wire logic        four_wire_command_mode,
    input  wire logic        array_busy,
    input  wire logic        array_op_done,
    input  wire logic        soft_reset,
    // Status view
    output logic [7:0]       status1_q,
    output logic [7:0]       status2_q,
    output logic [7:0]       status3_q,
    output logic             write_enable_latch_q,
    output logic             busy_q
);

    logic       cs_m_q, cs_s_q, cs_d_q;
    logic       sck_m_q, sck_s_q, sck_d_q;
    logic       si_m_q, si_s_q;
    logic       sck_rise, sck_fall, cs_rise;
    sfs_state_t state_q;
    sfs_pend_t  pend_q;
    logic [4:0] cnt_q;
    logic [4:0] dbits_q;
    logic [1:0] sel_q;
    logic [15:0] dat_q;
    logic [7:0] sh_nx;
    logic [2:0] ocnt_q;
    logic [7:0] hold_q, src_byte, cur_byte, stat_sel;
    logic [7:0] nv1_q, nv2_q, nv3_q;
    logic [7:0] p1_q, p2_q, p3_q;
    logic [2:0] pmask_q, wmask;
    logic       wip_q, vol_arm_q, vpend_q;
    logic [15:0] tmr_q;
    logic       busy_w, go, vol_go, wr_done, vol_done;
    logic [7:0] v1, m2;
    logic [7:0] keep2;

    // Two-stage synchronisers, plus one delay stage for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
            cs_d_q  <= 1'b1;
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_d_q <= 1'b0;
            si_m_q  <= 1'b0;
            si_s_q  <= 1'b0;
        end else begin
            cs_m_q  <= chip_select_n;
            cs_s_q  <= cs_m_q;
            cs_d_q  <= cs_s_q;
            sck_m_q <= serial_clk;
            sck_s_q <= sck_m_q;
            sck_d_q <= sck_s_q;
            si_m_q  <= serial_in;
            si_s_q  <= si_m_q;
        end
    end

    // Edges of the framed serial clock
    assign sck_rise = sck_s_q & ~sck_d_q & ~cs_s_q;
    assign sck_fall = ~sck_s_q & sck_d_q & ~cs_s_q;
    assign cs_rise  = cs_s_q & ~cs_d_q;
    assign sh_nx    = {dat_q[6:0], si_s_q};
    assign busy_w   = wip_q | array_busy;

    // Command decoder, bits taken on rising edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_CMD;
            pend_q  <= PC_NONE;
            cnt_q   <= 5'h00;
            dbits_q <= 5'h00;
            sel_q   <= 2'h0;
            dat_q   <= 16'h0000;
        end else if (cs_rise) begin
            state_q <= ST_CMD;
            pend_q  <= PC_NONE;
            cnt_q   <= 5'h00;
            dbits_q <= 5'h00;
        end else if (sck_rise) begin
            dat_q <= {dat_q[14:0], si_s_q};
            case (state_q)
                ST_CMD: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == LAST_OP_BIT) begin
                        cnt_q   <= 5'h00;
                        state_q <= ST_SKIP;
                        case (sh_nx)
                            OP_WR_EN:    pend_q <= PC_WR_EN;
                            OP_WR_DIS:   pend_q <= PC_WR_DIS;
                            OP_VOL_EN:   pend_q <= PC_VOL_EN;
                            OP_RD_STAT1: begin
                                sel_q   <= 2'h0;
                                state_q <= ST_STAT_OUT;
                            end
                            OP_RD_STAT2: begin
                                sel_q   <= 2'h1;
                                state_q <= ST_STAT_OUT;
                            end
                            OP_RD_STAT3: begin
                                sel_q   <= 2'h2;
                                state_q <= ST_STAT_OUT;
                            end
                            OP_WR_STAT1: begin
                                sel_q   <= 2'h0;
                                state_q <= ST_STAT_IN;
                            end
                            OP_WR_STAT2: begin
                                sel_q   <= 2'h1;
                                state_q <= ST_STAT_IN;
                            end
                            OP_WR_STAT3: begin
                                sel_q   <= 2'h2;
                                state_q <= ST_STAT_IN;
                            end
                            OP_READ: begin
                                if (!busy_w && !four_wire_command_mode) begin
                                    state_q <= ST_ADDR;
                                end
                            end
                            default: state_q <= ST_SKIP;
                        endcase
                    end
                end
                ST_ADDR: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == LAST_ADDR_BIT) begin
                        state_q <= ST_DATA_OUT;
                    end
                end
                ST_STAT_IN: begin
                    if (dbits_q != BITS_SAT) begin
                        dbits_q <= dbits_q + 5'h01;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // Address shift during the address phase, increment after each byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr_q <= 24'h000000;
        end else if (sck_rise && state_q == ST_ADDR) begin
            mem_addr_q <= {mem_addr_q[22:0], si_s_q};
        end else if (sck_fall && state_q == ST_DATA_OUT && ocnt_q == 3'h7) begin
            mem_addr_q <= mem_addr_q + 24'h000001;
        end
    end

    // Byte source for the output shifter
    always_comb begin
        case (sel_q)
            2'h0:    stat_sel = {status1_q[7:2], write_enable_latch_q, busy_w};
            2'h1:    stat_sel = status2_q;
            default: stat_sel = status3_q;
        endcase
        src_byte = (state_q == ST_STAT_OUT) ? stat_sel : mem_rdata;
        cur_byte = (ocnt_q == 3'h0) ? src_byte : hold_q;
    end

    // Output shifter, bits driven on falling edges, MSB first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ocnt_q          <= 3'h0;
            hold_q          <= 8'h00;
            serial_out_q    <= 1'b0;
            serial_out_en_q <= 1'b0;
        end else if (cs_s_q) begin
            ocnt_q          <= 3'h0;
            serial_out_en_q <= 1'b0;
        end else if (sck_fall && (state_q == ST_STAT_OUT || state_q == ST_DATA_OUT)) begin
            serial_out_q    <= cur_byte[3'h7 - ocnt_q];
            hold_q          <= cur_byte;
            ocnt_q          <= ocnt_q + 3'h1;
            serial_out_en_q <= 1'b1;
        end
    end

    // Status write decode at frame end
    always_comb begin
        wmask[0] = (sel_q == 2'h0) && (dbits_q == ONE_BYTE || dbits_q == TWO_BYTES);
        wmask[1] = ((sel_q == 2'h1) && dbits_q == ONE_BYTE)
                   || ((sel_q == 2'h0) && dbits_q == TWO_BYTES);
        wmask[2] = (sel_q == 2'h2) && dbits_q == ONE_BYTE;
        v1       = (dbits_q == TWO_BYTES) ? dat_q[15:8] : dat_q[7:0];
        m2       = four_wire_command_mode ? (SR2_WMASK & ~SR2_QE) : SR2_WMASK;
        keep2    = vol_arm_q ? (SR2_OTP_MASK | SR2_LOCK1) : SR2_OTP_MASK;
        go       = cs_rise && state_q == ST_STAT_IN && (wmask != 3'h0) && !busy_w;
        vol_go   = go && vol_arm_q;
        wr_done  = wip_q && (tmr_q == 16'h0000);
        vol_done = vpend_q && (tmr_q == 16'h0000);
    end

    // Status registers, stored copies, latch and write timing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status1_q <= SR1_RST;
            status2_q <= SR2_RST;
            status3_q <= SR3_RST;
            nv1_q     <= SR1_RST;
            nv2_q     <= SR2_RST;
            nv3_q     <= SR3_RST;
            p1_q      <= 8'h00;
            p2_q      <= 8'h00;
            p3_q      <= 8'h00;
            pmask_q   <= 3'h0;
            write_enable_latch_q <= 1'b0;
            wip_q     <= 1'b0;
            vpend_q   <= 1'b0;
            vol_arm_q <= 1'b0;
            tmr_q     <= 16'h0000;
        end else if (soft_reset) begin
            status1_q <= nv1_q;
            status2_q <= nv2_q;
            status3_q <= nv3_q;
            write_enable_latch_q <= 1'b0;
            wip_q     <= 1'b0;
            vpend_q   <= 1'b0;
            vol_arm_q <= 1'b0;
        end else begin
            if (cs_rise) begin
                vol_arm_q <= (pend_q == PC_VOL_EN);
                if (pend_q == PC_WR_EN) begin
                    write_enable_latch_q <= 1'b1;
                end else if (pend_q == PC_WR_DIS) begin
                    write_enable_latch_q <= 1'b0;
                end
            end
            if (go && (vol_arm_q || write_enable_latch_q)) begin
                p1_q    <= (status1_q & ~SR1_WMASK) | (v1 & SR1_WMASK);
                p2_q    <= (status2_q & ~m2) | (dat_q[7:0] & m2) | (status2_q & keep2);
                p3_q    <= (status3_q & ~SR3_WMASK) | (dat_q[7:0] & SR3_WMASK);
                pmask_q <= wmask;
                if (vol_go) begin
                    vpend_q <= 1'b1;
                    tmr_q   <= 16'(REFRESH_CYCLES - 1);
                end else begin
                    wip_q   <= 1'b1;
                    tmr_q   <= 16'(STATUS_WRITE_CYCLES - 1);
                end
            end else if (tmr_q != 16'h0000) begin
                tmr_q <= tmr_q - 16'h0001;
            end
            if (wr_done || vol_done) begin
                wip_q   <= 1'b0;
                vpend_q <= 1'b0;
                if (pmask_q[0]) status1_q <= p1_q;
                if (pmask_q[1]) status2_q <= p2_q;
                if (pmask_q[2]) status3_q <= p3_q;
            end
            if (wr_done) begin
                if (pmask_q[0]) nv1_q <= p1_q;
                if (pmask_q[1]) nv2_q <= p2_q;
                if (pmask_q[2]) nv3_q <= p3_q;
            end
            if (wr_done || array_op_done) begin
                write_enable_latch_q <= 1'b0;
            end
        end
    end

    // Registered busy view
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_w;
        end
    end

endmodule

// file: sfs_status_read_props.sv
// Purpose: Port-level checks of the status and read sequencer.
// Assumes: Bench never starts a status write while array_busy is high.
// Notes:   A soft reset window masks the sticky-bit and quad-enable checks.
`timescale 1ns/1ps
module sfs_status_read_props
    import sfs_pkg::*;
#(
    parameter int STATUS_WRITE_CYCLES = STATUS_WRITE_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Host pins
    input  wire logic       chip_select_n,
    input  wire logic       serial_out_en_q,
    // Mode and engine
    input  wire logic       four_wire_command_mode,
    input  wire logic       array_busy,
    input  wire logic       array_op_done,
    input  wire logic       soft_reset,
    // Status view
    input  wire logic [7:0] status1_q,
    input  wire logic [7:0] status2_q,
    input  wire logic [7:0] status3_q,
    input  wire logic       write_enable_latch_q,
    input  wire logic       busy_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic sr1_q;
    logic sr2_q;
    logic ab_q;
    int   bcnt_q;
    // Soft reset history, array busy history, busy run length
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr1_q  <= 1'b0;
            sr2_q  <= 1'b0;
            ab_q   <= 1'b0;
            bcnt_q <= 0;
        end else begin
            sr1_q  <= soft_reset;
            sr2_q  <= sr1_q;
            ab_q   <= array_busy | (ab_q & busy_q);
            bcnt_q <= busy_q ? bcnt_q + 1 : 0;
        end
    end
    a_wel_auto_clear: assert property (
        (array_op_done || soft_reset) |-> ##[1:3] !write_enable_latch_q)
        else $error("latch not cleared after operation end or reset");
    a_ro_bits_fixed: assert property (
        ((status1_q ^ SR1_RST) & ~SR1_WMASK) == 8'h00
        && ((status2_q ^ SR2_RST) & ~SR2_WMASK) == 8'h00
        && ((status3_q ^ SR3_RST) & ~SR3_WMASK) == 8'h00)
        else $error("read-only status bit changed");
    a_otp_bits_sticky: assert property (
        !(soft_reset || sr1_q || sr2_q)
        |-> ($past(status2_q) & ~status2_q & SR2_OTP_MASK) == 8'h00)
        else $error("security lock bit returned to zero");
    a_qe_four_wire: assert property (
        four_wire_command_mode && $past(four_wire_command_mode)
        && !(soft_reset || sr1_q || sr2_q) |-> $stable(status2_q[1]))
        else $error("quad enable changed in four-wire mode");
    a_wr_cycle_len: assert property (
        $fell(busy_q) && !ab_q
        |-> bcnt_q == STATUS_WRITE_CYCLES && !write_enable_latch_q)
        else $error("write cycle length or latch clear wrong");
    a_wel_framed: assert property (
        $rose(write_enable_latch_q) |-> chip_select_n && $past(chip_select_n, 2))
        else $error("latch set inside a frame");
    a_busy_after_cs: assert property (
        $rose(busy_q) && !ab_q && !array_busy |-> chip_select_n)
        else $error("write cycle started inside a frame");
    a_out_idle_cs: assert property (
        chip_select_n [*6] |-> !serial_out_en_q)
        else $error("output driven with chip select high");
    // Main scenarios seen
    c_write_cycle: cover property ($fell(busy_q) && !ab_q);
    c_out_driven: cover property ($rose(serial_out_en_q));
    c_wel_set: cover property ($rose(write_enable_latch_q));
endmodule

bind sfs_status_read sfs_status_read_props #(
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)
) i_sfs_status_read_props (
    .clk(clk), .rstn(rstn), .chip_select_n(chip_select_n),
    .serial_out_en_q(serial_out_en_q), .four_wire_command_mode(four_wire_command_mode),
    .array_busy(array_busy), .array_op_done(array_op_done), .soft_reset(soft_reset),
    .status1_q(status1_q), .status2_q(status2_q), .status3_q(status3_q),
    .write_enable_latch_q(write_enable_latch_q), .busy_q(busy_q)
);

// file: sfs_array_model.sv
// Purpose: Array read model behind the sequencer's memory port.
// Assumes: One-clock registered lookup.
// Notes:   Byte pattern is the low address byte xor a5h.
`timescale 1ns/1ps
module sfs_array_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Read port
    input  wire logic [23:0] mem_addr_q,
    output logic      [7:0]  mem_rdata
);
    // Registered lookup, valid one clock after the address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_rdata <= 8'h00;
        end else begin
            mem_rdata <= mem_addr_q[7:0] ^ 8'ha5;
        end
    end
endmodule

// file: tb_sfs_status_read.sv
// Purpose: Self-checking bench of the status and read sequencer.
// Assumes: Serial clock phases of six system clocks, mode 0.
// Notes:   Short write cycle parameter keeps the run brief.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %s exp %h got %h", nm, e, a); end end
module tb_sfs_status_read;
    import sfs_pkg::*;
    localparam int SW = 400;
    logic clk = 1'b0, rstn = 1'b0, chip_select_n = 1'b1, serial_clk = 1'b0;
    logic serial_in = 1'b0, serial_out_q, serial_out_en_q, write_enable_latch, busy_q;
    logic four_wire = 1'b0, array_busy = 1'b0, op_done = 1'b0, soft_reset = 1'b0;
    logic [23:0] mem_addr_q;
    logic [7:0]  mem_rdata, st1, st2, st3;
    logic [63:0] r;
    logic        en_any;
    int          failures = 0, checks = 0, cyc = 0;
    always #10 clk = ~clk;
    sfs_status_read #(.STATUS_WRITE_CYCLES(SW), .REFRESH_CYCLES(2)) i_sfs_status_read (
        .clk(clk), .rstn(rstn), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out_q(serial_out_q), .serial_out_en_q(serial_out_en_q),
        .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata), .four_wire_command_mode(four_wire),
        .array_busy(array_busy), .array_op_done(op_done), .soft_reset(soft_reset),
        .status1_q(st1), .status2_q(st2), .status3_q(st3),
        .write_enable_latch_q(write_enable_latch), .busy_q(busy_q));
    sfs_array_model i_sfs_array_model (
        .clk(clk), .rstn(rstn), .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One framed command, bits MSB first, output sampled late in each low phase
    task automatic frame(input logic [63:0] d, input int n);
        r = '0;
        en_any = 1'b0;
        @(posedge clk) chip_select_n <= 1'b0;
        tick(6);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= d[i];
            tick(5);
            @(negedge clk);
            r = {r[62:0], serial_out_q};
            en_any = en_any | serial_out_en_q;
            @(posedge clk) serial_clk <= 1'b1;
            tick(6);
            serial_clk <= 1'b0;
        end
        tick(6);
        chip_select_n <= 1'b1;
        tick(8);
    endtask
    // One-cycle pulse on the done line (sel 0) or the reset line (sel 1)
    task automatic pulse(input bit sel);
        @(posedge clk) begin
            if (sel) begin
                soft_reset <= 1'b1;
            end else begin
                op_done <= 1'b1;
            end
        end
        @(posedge clk) begin
            soft_reset <= 1'b0;
            op_done    <= 1'b0;
        end
        tick(3);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        tick(12);
        rstn <= 1'b1;
        tick(2);
        `CHK("wel", 1'b0, write_enable_latch)
        frame({56'h0, OP_WR_EN}, 8);
        `CHK("wel", 1'b1, write_enable_latch)
        frame({56'h0, OP_WR_DIS}, 8);
        `CHK("wel", 1'b0, write_enable_latch)
        $display("test latch done");
        frame({56'h0, OP_WR_EN}, 8);
        frame({48'h0, OP_WR_STAT1, 8'hff}, 16);
        `CHK("busy", 1'b1, busy_q)
        frame({48'h0, OP_RD_STAT1, 8'h00}, 16);
        `CHK("poll", 2'b11, r[1:0])
        for (int k = 0; k < 600 && busy_q !== 1'b0; k++) tick(1);
        `CHK("busy", 1'b0, busy_q)
        `CHK("st1", 8'hfc, st1)
        `CHK("wel", 1'b0, write_enable_latch)
        frame({48'h0, OP_WR_STAT2, 8'hff}, 16);
        tick(SW);
        `CHK("st2", 8'h00, st2)
        $display("test nonvolatile done");
        frame({56'h0, OP_VOL_EN}, 8);
        frame({48'h0, OP_WR_STAT2, 8'hff}, 16);
        `CHK("st2", 8'h7b, st2)
        `CHK("busy", 1'b0, busy_q)
        `CHK("wel", 1'b0, write_enable_latch)
        frame({56'h0, OP_VOL_EN}, 8);
        frame({48'h0, OP_WR_STAT2, 8'h00}, 16);
        `CHK("st2", 8'h39, st2)
        frame({56'h0, OP_VOL_EN}, 8);
        frame({40'h0, OP_WR_STAT1, 16'h8442}, 24);
        `CHK("st12", 16'h847b, {st1, st2})
        frame({56'h0, OP_VOL_EN}, 8);
        frame({48'h0, OP_WR_STAT1, 8'h0c}, 16);
        `CHK("st12", 16'h0c7b, {st1, st2})
        frame({56'h0, OP_VOL_EN}, 8);
        frame({48'h0, OP_WR_STAT3, 8'hff}, 16);
        frame({48'h0, OP_RD_STAT3, 8'h00}, 16);
        `CHK("rd3", 8'he6, r[7:0])
        frame({40'h0, OP_RD_STAT2, 16'h0}, 24);
        `CHK("rd2", 16'h7b7b, r[15:0])
        $display("test volatile done");
        @(posedge clk) four_wire <= 1'b1;
        frame({56'h0, OP_VOL_EN}, 8);
        frame({48'h0, OP_WR_STAT2, 8'h00}, 16);
        `CHK("st2", 8'h3b, st2)
        frame({16'h0, OP_READ, 24'hffffff, 16'h0}, 48);
        `CHK("en", 1'b0, en_any)
        @(posedge clk) four_wire <= 1'b0;
        frame({16'h0, OP_READ, 24'hffffff, 16'h0}, 48);
        `CHK("data", 16'h5aa5, r[15:0])
        `CHK("en", 1'b1, en_any)
        @(posedge clk) array_busy <= 1'b1;
        frame({16'h0, OP_READ, 24'h000010, 16'h0}, 48);
        `CHK("en", 1'b0, en_any)
        @(posedge clk) array_busy <= 1'b0;
        tick(4);
        frame({56'h0, OP_WR_EN}, 8);
        pulse(1'b0);
        `CHK("wel", 1'b0, write_enable_latch)
        $display("test read done");
        frame({56'h0, OP_WR_EN}, 8);
        pulse(1'b1);
        `CHK("st123", 24'hfc0000, {st1, st2, st3})
        `CHK("wel", 1'b0, write_enable_latch)
        $display("test reset done");
        tally_and_finish();
    end
endmodule
